// ==== logic/rit_pkg.sv ====
package rit_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 24;

    localparam logic [ADDR_W-1:0] COUNTER_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] RELOAD_OFF = 8'h04;

    localparam int RELOAD_MSB = 23;
    localparam int ENABLE_BIT = 24;
    localparam int PENDING_BIT = 25;
    localparam int OVERFLOW_BIT = 26;

    localparam logic [COUNT_W-1:0] COUNT_RST = 24'hFFFFFF;
    localparam logic [COUNT_W-1:0] RELOAD_RST = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam logic ENABLE_RST = 1'b0;
    localparam logic PENDING_RST = 1'b0;
    localparam logic OVERFLOW_RST = 1'b0;
    localparam logic [DATA_W-1:0] READ_NONE = 32'h00000000;

    function automatic logic rit_hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] offset
    );
        rit_hit = (addr == offset);
    endfunction : rit_hit

endpackage : rit_pkg

// ==== logic/rit_down_counter.sv ====
`timescale 1ns/10ps
module rit_down_counter (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic loadStrobe,
    input wire logic [rit_pkg::COUNT_W-1:0] loadValue,
    input wire logic [rit_pkg::COUNT_W-1:0] reloadValue,
    output logic [rit_pkg::COUNT_W-1:0] countValue,
    output logic reloadEvent
);
    import rit_pkg::*;

    logic [COUNT_W-1:0] countValue_reg;

    // High in the cycle the count stands at zero; the next edge reloads.
    assign reloadEvent = (countValue_reg == COUNT_ZERO);

    // A software load wins over both decrement and reload.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            countValue_reg <= COUNT_RST;
        end else if (loadStrobe) begin
            countValue_reg <= loadValue;
        end else if (reloadEvent) begin
            countValue_reg <= reloadValue;
        end else begin
            countValue_reg <= countValue_reg - COUNT_ONE;
        end
    end

    assign countValue = countValue_reg;

endmodule : rit_down_counter

// ==== logic/rit_timer.sv ====
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// - 24-bit count decrements by one every cycle
// - Zero count reloads from reload value next cycle
// - Pending flag sets together with the reload
// - Reload register: value, overflow, pending, enable
// - Interrupt raised while pending and enable set
// - Zero while pending already set sets overflow
// - Reload write leaves running count untouched
// - Timer interrupt masked by its own enable
// - Registers reachable only in supervisor mode
module rit_timer (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic supervisorMode,
    input wire logic [rit_pkg::ADDR_W-1:0] regAddr,
    input wire logic [rit_pkg::DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [rit_pkg::DATA_W-1:0] regRdata,
    output logic timerIrq
);
    import rit_pkg::*;

    logic [COUNT_W-1:0] countValue;
    logic [COUNT_W-1:0] reloadValue_reg;
    logic interruptEnableBit_reg;
    logic pendingFlag_reg;
    logic overflowFlag_reg;
    logic reloadEvent;
    logic counterWrite;
    logic reloadWrite;
    logic counterRead;
    logic reloadRead;
    logic [DATA_W-1:0] readData_next;
    logic [DATA_W-1:0] regRdata_reg;

    // User-mode accesses are dropped: writes change nothing, reads give 0.
    assign counterWrite = regWrite && supervisorMode &&
        rit_hit(regAddr, COUNTER_OFF);
    assign reloadWrite = regWrite && supervisorMode &&
        rit_hit(regAddr, RELOAD_OFF);
    assign counterRead = regRead && supervisorMode &&
        rit_hit(regAddr, COUNTER_OFF);
    assign reloadRead = regRead && supervisorMode &&
        rit_hit(regAddr, RELOAD_OFF);

    rit_down_counter u_counter (
        .sys_clk(sys_clk),
        .srst(srst),
        .loadStrobe(counterWrite),
        .loadValue(regWdata[RELOAD_MSB:0]),
        .reloadValue(reloadValue_reg),
        .countValue(countValue),
        .reloadEvent(reloadEvent)
    );

    // The reload value only feeds the counter at the next zero.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reloadValue_reg <= RELOAD_RST;
        end else if (reloadWrite) begin
            reloadValue_reg <= regWdata[RELOAD_MSB:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            interruptEnableBit_reg <= ENABLE_RST;
        end else if (reloadWrite) begin
            interruptEnableBit_reg <= regWdata[ENABLE_BIT];
        end
    end

    // A reload sets pending even if software clears it in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pendingFlag_reg <= PENDING_RST;
        end else if (reloadEvent) begin
            pendingFlag_reg <= 1'b1;
        end else if (reloadWrite) begin
            pendingFlag_reg <= regWdata[PENDING_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            overflowFlag_reg <= OVERFLOW_RST;
        end else if (reloadEvent && pendingFlag_reg) begin
            overflowFlag_reg <= 1'b1;
        end else if (reloadWrite) begin
            overflowFlag_reg <= regWdata[OVERFLOW_BIT];
        end
    end

    // No other interrupt mask takes part here.
    assign timerIrq = pendingFlag_reg &&
        interruptEnableBit_reg;

    always_comb begin
        readData_next = READ_NONE;
        if (counterRead) begin
            readData_next[RELOAD_MSB:0] = countValue;
        end else if (reloadRead) begin
            readData_next[RELOAD_MSB:0] = reloadValue_reg;
            readData_next[ENABLE_BIT] = interruptEnableBit_reg;
            readData_next[PENDING_BIT] = pendingFlag_reg;
            readData_next[OVERFLOW_BIT] = overflowFlag_reg;
        end
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            regRdata_reg <= READ_NONE;
        end else begin
            regRdata_reg <= readData_next;
        end
    end

    assign regRdata = regRdata_reg;

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (srst);

    chk_count_decrement: assert property (
        (countValue != COUNT_ZERO) && !counterWrite
        |=> countValue == $past(countValue) - COUNT_ONE
    ) else $error("Count did not decrement by one.");

    chk_zero_reload: assert property (
        reloadEvent && !counterWrite
        |=> countValue == $past(reloadValue_reg)
    ) else $error("Zero count did not reload.");

    chk_pending_with_reload: assert property (
        reloadEvent && !counterWrite
        |=> pendingFlag_reg && (countValue == $past(reloadValue_reg))
    ) else $error("Pending flag not set with the reload.");

    chk_reload_readback: assert property (
        reloadRead
        |=> regRdata[RELOAD_MSB:0] == $past(reloadValue_reg) &&
            regRdata[ENABLE_BIT] == $past(interruptEnableBit_reg) &&
            regRdata[PENDING_BIT] == $past(pendingFlag_reg) &&
            regRdata[OVERFLOW_BIT] == $past(overflowFlag_reg) &&
            regRdata[DATA_W-1:OVERFLOW_BIT+1] == '0
    ) else $error("Reload register read back wrong.");

    chk_irq_after_zero: assert property (
        reloadEvent && interruptEnableBit_reg && !reloadWrite
        |=> timerIrq
    ) else $error("Interrupt missing after zero with enable set.");

    chk_overflow_set: assert property (
        reloadEvent && pendingFlag_reg
        |=> overflowFlag_reg && pendingFlag_reg
    ) else $error("Overflow not set on zero while pending.");

    chk_write_keeps_count: assert property (
        reloadWrite && !counterWrite && (countValue > COUNT_ONE)
        ##1 !counterWrite
        |=> countValue == $past(countValue, 2) - COUNT_ONE - COUNT_ONE
    ) else $error("Reload write disturbed the running count.");

    chk_irq_own_mask: assert property (
        reloadWrite && !regWdata[ENABLE_BIT] |=> !timerIrq
    ) else $error("Interrupt raised with enable clear.");

    chk_user_no_write: assert property (
        regWrite && !supervisorMode
        |=> $stable(reloadValue_reg) && $stable(interruptEnableBit_reg)
    ) else $error("User-mode write changed the reload register.");

    chk_user_read_zero: assert property (
        regRead && !supervisorMode |=> regRdata == READ_NONE
    ) else $error("User-mode read returned data.");

    chk_set_beats_clear: assert property (
        reloadWrite && reloadEvent && !regWdata[PENDING_BIT]
        |=> pendingFlag_reg
    ) else $error("Software clear beat the hardware set.");

    chk_overflow_beats_clear: assert property (
        reloadWrite && reloadEvent && pendingFlag_reg &&
            !regWdata[OVERFLOW_BIT]
        |=> overflowFlag_reg
    ) else $error("Software clear beat the overflow set.");

    chk_counter_readback: assert property (
        counterRead
        |=> regRdata == {{(DATA_W - COUNT_W){1'b0}}, $past(countValue)}
    ) else $error("Counter register read back wrong.");

    chk_enable_write: assert property (
        reloadWrite
        |=> interruptEnableBit_reg == $past(regWdata[ENABLE_BIT])
    ) else $error("Enable bit did not take the written value.");

    chk_read_idle_zero: assert property (
        !regRead |=> regRdata == READ_NONE
    ) else $error("Read data stood beyond one cycle.");

    chk_flags_hold: assert property (
        !reloadEvent && !reloadWrite
        |=> $stable(pendingFlag_reg) && $stable(overflowFlag_reg)
    ) else $error("Flag changed with no zero and no write.");

    cov_reload: cover property (reloadEvent ##1 timerIrq);
    cov_overflow: cover property (reloadEvent && pendingFlag_reg);
    cov_service: cover property (
        timerIrq ##1 (reloadWrite && !regWdata[PENDING_BIT]) ##1 !timerIrq
    );
    cov_user_blocked: cover property (regWrite && !supervisorMode);
    cov_write_at_zero: cover property (reloadWrite && reloadEvent);

endmodule : rit_timer

// ==== dv/rit_testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import rit_pkg::*;

    typedef struct packed {
        logic [ADDR_W-1:0] wAddr;
        logic [DATA_W-1:0] wData;
        logic wSup;
        logic [ADDR_W-1:0] rAddr;
        logic rSup;
        logic [DATA_W-1:0] rExp;
    } rit_row_t;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic supervisorMode = 1'b0;
    logic [ADDR_W-1:0] regAddr = 8'h00;
    logic [DATA_W-1:0] regWdata = 32'h00000000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic timerIrq;
    int mismatches = 0;
    int comparisons = 0;
    rit_row_t rows [5];

    rit_timer i_rit_timer (
        .sys_clk(sys_clk),
        .srst(srst),
        .supervisorMode(supervisorMode),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdata(regRdata),
        .timerIrq(timerIrq)
    );

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    task chk(input string what, input logic [DATA_W-1:0] expv,
             input logic [DATA_W-1:0] got);
        comparisons++;
        if (got !== expv) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic s);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        supervisorMode <= s;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr

    // Read data are looked at only in the cycle after the strobe.
    task rd(input logic [ADDR_W-1:0] a, input logic s,
            input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        supervisorMode <= s;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        chk("regRdata", e, regRdata);
    endtask : rd

    task irq(input logic e);
        #1;
        chk("timerIrq", {31'h0, e}, {31'h0, timerIrq});
    endtask : irq

    task summarize;
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        tick(2000);
        mismatches++;
        summarize();
    end

    initial begin
        rows[0] = '{RELOAD_OFF, 32'hF8ABCDEF, 1'b1, RELOAD_OFF, 1'b1,
                    32'h00ABCDEF};
        rows[1] = '{RELOAD_OFF, 32'h01123456, 1'b0, RELOAD_OFF, 1'b1,
                    32'h00ABCDEF};
        rows[2] = '{8'h08, 32'hFFFFFFFF, 1'b1, 8'h08, 1'b1, 32'h00000000};
        rows[3] = '{RELOAD_OFF, 32'h00000014, 1'b1, RELOAD_OFF, 1'b0,
                    32'h00000000};
        rows[4] = '{COUNTER_OFF, 32'hFF000100, 1'b1, COUNTER_OFF, 1'b1,
                    32'h000000FF};
        tick(10);
        srst <= 1'b0;
        rd(RELOAD_OFF, 1'b1, 32'h00000000);
        foreach (rows[i]) begin
            wr(rows[i].wAddr, rows[i].wData, rows[i].wSup);
            rd(rows[i].rAddr, rows[i].rSup, rows[i].rExp);
        end
        // First interval of five, then reload of twenty with enable set.
        wr(COUNTER_OFF, 32'h00000005, 1'b1);
        wr(RELOAD_OFF, 32'h01000014, 1'b1);
        tick(3);
        irq(1'b0);
        tick(1);
        irq(1'b1);
        rd(COUNTER_OFF, 1'b1, 32'h00000013);
        rd(RELOAD_OFF, 1'b1, 32'h03000014);
        tick(25);
        rd(RELOAD_OFF, 1'b1, 32'h07000014);
        // A reload write in mid-interval must not touch the running count.
        wr(COUNTER_OFF, 32'h0000000A, 1'b1);
        wr(RELOAD_OFF, 32'h00000030, 1'b1);
        irq(1'b0);
        rd(COUNTER_OFF, 1'b1, 32'h00000007);
        tick(8);
        irq(1'b0);
        rd(COUNTER_OFF, 1'b1, 32'h0000002E);
        rd(RELOAD_OFF, 1'b1, 32'h02000030);
        // The flag clear lands on the very edge of the reload.
        wr(COUNTER_OFF, 32'h00000004, 1'b1);
        tick(3);
        wr(RELOAD_OFF, 32'h01000030, 1'b1);
        irq(1'b1);
        rd(RELOAD_OFF, 1'b1, 32'h07000030);
        @(posedge sys_clk);
        srst <= 1'b1;
        @(posedge sys_clk);
        srst <= 1'b0;
        irq(1'b0);
        rd(COUNTER_OFF, 1'b1, 32'h00FFFFFE);
        rd(RELOAD_OFF, 1'b1, 32'h00000000);
        summarize();
    end
endmodule : testbench
